// ==== pkg/epl_pkg.sv ====
// constants for the register preload block
package epl_pkg;

   // apb map: loader registers, control registers at index*4, memory window
   localparam logic [11:0] ADDR_CMD     = 12'h000;
   localparam logic [11:0] ADDR_SRC_LO  = 12'h004;
   localparam logic [11:0] ADDR_SRC_HI  = 12'h008;
   localparam logic [11:0] ADDR_STATUS  = 12'h00C;
   localparam logic [2:0]  NVM_WIN_SEL  = 3'h1;      // paddr[11:9]
   localparam logic [3:0]  REG_WIN_SEL  = 4'h0;      // paddr[11:8]

   // control register range and load geometry
   localparam logic [5:0]  REG_FIRST    = 6'h10;
   localparam logic [5:0]  REG_LAST     = 6'h2F;
   localparam logic [4:0]  COPY_FIRST   = 5'h01;
   localparam logic [4:0]  COPY_LAST    = 5'h1F;
   localparam int          NVM_BYTES    = 128;
   localparam logic [6:0]  PWRUP_BASE   = 7'h10;
   localparam logic [6:0]  VICIN_BASE   = 7'h30;
   localparam logic [6:0]  SET_SPAN     = 7'h20;
   localparam logic [15:0] CMD_SRC_MIN  = 16'h0030;
   localparam logic [15:0] CMD_SRC_MAX  = 16'h0060;

   // field positions
   localparam int CMD_START_BIT  = 0;
   localparam int ST_BUSY_BIT    = 0;
   localparam int ST_DONE_BIT    = 1;
   localparam int ST_ERR_BIT     = 2;

   // factory image of the power-up set, first byte at memory 10h
   localparam logic [0:31][7:0] SET_PROX = {
      8'h00, 8'h58, 8'h3F, 8'h3F, 8'h19, 8'h13, 8'h3F, 8'h3B,
      8'h00, 8'h73, 8'h08, 8'hAD, 8'hFF, 8'h1E, 8'h41, 8'h00,
      8'h00, 8'h06, 8'h03, 8'h63, 8'h63, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h08, 8'h07, 8'h06, 8'h0A, 8'h02, 8'h00, 8'h00
   };

   // factory image of the vicinity-label set, first byte at memory 30h
   localparam logic [0:31][7:0] SET_VICIN = {
      8'h00,
      8'h58,
      8'h3F,
      8'h05,
      8'h2C,
      8'h3F, 8'h3F, 8'h00, 8'h00,
      8'h8B,
      8'h00,
      8'h54,
      8'h68,
      8'h00,
      8'h41,
      8'h00, 8'h00,
      8'h08,
      8'h0C,
      8'hFE,
      8'hFF,
      8'h00, 8'h00, 8'h00, 8'h00,
      8'h3E,
      8'h0B,
      8'h02,
      8'h00,
      8'h02,
      8'h00, 8'h00
   };

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_COPY   = 3'b010,
      ST_FINISH = 3'b100
   } epl_state_t;

endpackage

// ==== verilog/epl_preload.sv ====
// register preload engine with its memory, control registers and apb slave
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module epl_preload
   import epl_pkg::*;
(
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // control register contents, register 10h in byte 0
   output logic [31:0][7:0]       cfg_regs,
   // loader state
   output logic                   load_busy,
   output logic                   load_done
);

   epl_state_t         state_ff;
   logic [4:0]         idx_ff;
   logic [6:0]         base_ff;
   logic [7:0]         src_lo_ff;
   logic [7:0]         src_hi_ff;
   logic [31:0][7:0]   regs_ff;
   logic [7:0]         nvm_mem [NVM_BYTES];
   logic [NVM_BYTES-1:0] nvm_wr_ff;
   logic               done_ff;
   logic               err_ff;
   logic [31:0]        prdata_ff;
   logic               pready_ff;
   logic               pslverr_ff;
   logic [31:0]        nxt_rdata;
   logic               nxt_err;
   logic               setup;
   logic               acc_wr;
   logic [15:0]        src_addr;
   logic               src_ok;
   logic               start_req;
   logic               busy;
   logic [6:0]         rd_addr;
   // one decoded strobe per target, so every write path shares a qualifier
   logic               hit_reg;
   logic               hit_nvm;
   logic               wr_reg;
   logic               wr_nvm;
   logic               wr_src_lo;
   logic               wr_src_hi;
   logic               wr_status;
   logic               start_ok;
   logic               start_bad;

   // untouched bytes read as the factory image, so no memory reset is needed
   function automatic logic [7:0] factory_byte(input logic [6:0] a);
      logic [6:0] off;
      off = 7'h00;
      if (a >= PWRUP_BASE && a < PWRUP_BASE + SET_SPAN) begin
         off = a - PWRUP_BASE;
         return SET_PROX[off[4:0]];
      end
      if (a >= VICIN_BASE && a < VICIN_BASE + SET_SPAN) begin
         off = a - VICIN_BASE;
         return SET_VICIN[off[4:0]];
      end
      return 8'h00;
   endfunction

   // register window hit: aligned word index within 10h..2Fh
   function automatic logic reg_hit(input logic [11:0] a);
      return a[11:8] == REG_WIN_SEL && a[1:0] == 2'b00
             && a[7:2] >= REG_FIRST && a[7:2] <= REG_LAST;
   endfunction

   // register r sits at word 4*r; byte k of the bank is register 10h+k,
   // so the word index has to be rebased, not just truncated
   function automatic logic [4:0] reg_idx(input logic [11:0] a);
      logic [5:0] r;
      r = a[7:2] - REG_FIRST;
      return r[4:0];
   endfunction

   function automatic logic nvm_hit(input logic [11:0] a);
      return a[11:9] == NVM_WIN_SEL && a[1:0] == 2'b00;
   endfunction

   assign busy     = state_ff != ST_IDLE;
   assign setup    = psel & ~penable;
   assign acc_wr   = psel & penable & pready_ff & pwrite & ~pslverr_ff;
   assign src_addr = {src_hi_ff, src_lo_ff};
   assign src_ok   = src_addr >= CMD_SRC_MIN && src_addr <= CMD_SRC_MAX;
   assign start_req = acc_wr && paddr == ADDR_CMD
                      && pwdata[CMD_START_BIT];
   assign rd_addr  = base_ff + {2'b00, idx_ff};
   assign hit_reg   = reg_hit(paddr);
   assign hit_nvm   = nvm_hit(paddr);
   assign wr_reg    = acc_wr & hit_reg;
   assign wr_nvm    = acc_wr & hit_nvm;
   assign wr_src_lo = acc_wr & (paddr == ADDR_SRC_LO);
   assign wr_src_hi = acc_wr & (paddr == ADDR_SRC_HI);
   assign wr_status = acc_wr & (paddr == ADDR_STATUS);
   // start_req already excludes busy: a refused write never reaches acc_wr
   assign start_ok  = start_req & src_ok;
   assign start_bad = start_req & ~src_ok;

   // loader sequencer; starts from reset with the factory file
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_COPY;
         base_ff  <= PWRUP_BASE;
         idx_ff   <= COPY_FIRST;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (start_ok) begin
                  state_ff <= ST_COPY;
                  base_ff  <= src_addr[6:0];
                  idx_ff   <= COPY_FIRST;
               end
            end
            ST_COPY: begin
               if (idx_ff == COPY_LAST) begin
                  state_ff <= ST_FINISH;
               end else begin
                  idx_ff <= idx_ff + 5'h01;
               end
            end
            ST_FINISH: begin
               state_ff <= ST_IDLE;
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // control registers; the loader never writes byte 0 (register 10h)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regs_ff <= '0;
      end else if (state_ff == ST_COPY) begin
         regs_ff[idx_ff] <= nvm_mem_rd(rd_addr);
      end else if (wr_reg) begin
         regs_ff[reg_idx(paddr)] <= pwdata[7:0];
      end
   end

   function automatic logic [7:0] nvm_mem_rd(input logic [6:0] a);
      return nvm_wr_ff[a] ? nvm_mem[a] : factory_byte(a);
   endfunction

   // host access to the memory as ordinary user bytes
   always_ff @(posedge pclk) begin
      if (wr_nvm) begin
         nvm_mem[paddr[8:2]] <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nvm_wr_ff <= '0;
      end else if (wr_nvm) begin
         nvm_wr_ff[paddr[8:2]] <= 1'b1;
      end
   end

   // two-byte start address argument
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_lo_ff <= 8'h00;
         src_hi_ff <= 8'h00;
      end else if (wr_src_lo) begin
         src_lo_ff <= pwdata[7:0];
      end else if (wr_src_hi) begin
         src_hi_ff <= pwdata[7:0];
      end
   end

   // sticky flags: hardware set wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_ff <= 1'b0;
      end else if (state_ff == ST_FINISH) begin
         done_ff <= 1'b1;
      end else if (wr_status && pwdata[ST_DONE_BIT]) begin
         done_ff <= 1'b0;
      end else if (start_ok) begin
         done_ff <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_ff <= 1'b0;
      end else if (start_bad) begin
         err_ff <= 1'b1;
      end else if (wr_status && pwdata[ST_ERR_BIT]) begin
         err_ff <= 1'b0;
      end
   end

   // decode in the setup phase; answer is ready in the first access cycle
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      nxt_err   = 1'b0;
      if (hit_reg) begin
         nxt_rdata[7:0] = regs_ff[reg_idx(paddr)];
         nxt_err        = pwrite & busy;   // loader owns the registers
      end else if (hit_nvm) begin
         nxt_rdata[7:0] = nvm_mem_rd(paddr[8:2]);
         nxt_err        = pwrite & busy;
      end else begin
         case (paddr)
            ADDR_CMD:    nxt_err = pwrite & busy;
            ADDR_SRC_LO: begin
               nxt_rdata[7:0] = src_lo_ff;
               nxt_err        = pwrite & busy;
            end
            ADDR_SRC_HI: begin
               nxt_rdata[7:0] = src_hi_ff;
               nxt_err        = pwrite & busy;
            end
            ADDR_STATUS: begin
               nxt_rdata[ST_BUSY_BIT] = busy;
               nxt_rdata[ST_DONE_BIT] = done_ff;
               nxt_rdata[ST_ERR_BIT]  = err_ff;
            end
            default:     nxt_err = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= setup;
         if (setup) begin
            prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_rdata;
            pslverr_ff <= nxt_err;
         end else begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
         end
      end
   end

   // busy and done mirrored into flops so the ports come from registers
   logic busy_out_ff;
   logic done_out_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_out_ff <= 1'b1;
         done_out_ff <= 1'b0;
      end else begin
         busy_out_ff <= busy;
         done_out_ff <= done_ff;
      end
   end

   assign prdata    = prdata_ff;
   assign pready    = pready_ff;
   assign pslverr   = pslverr_ff;
   assign cfg_regs  = regs_ff;
   assign load_busy = busy_out_ff;
   assign load_done = done_out_ff;

endmodule

// ==== tb/epl_chk.sv ====
// concurrent checks on the ports of the register preload block
`timescale 1ns/100ps
module epl_chk
   import epl_pkg::*;
(
   // clock and reset
   input wire logic             pclk,
   input wire logic             presetn,
   // apb
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [11:0]      paddr,
   input wire logic [31:0]      pwdata,
   input wire logic [31:0]      prdata,
   input wire logic             pready,
   input wire logic             pslverr,
   // loader
   input wire logic [31:0][7:0] cfg_regs,
   input wire logic             load_busy,
   input wire logic             load_done
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready)
      else $error("no answer after setup");
   property p_lone; pready |-> psel && penable && !$past(penable); endproperty
   a_lone: assert property (p_lone)
      else $error("answer outside first access cycle");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err)
      else $error("error flag without ready");
   property p_rdz; !pready |-> prdata == 32'h0; endproperty
   a_rdz: assert property (p_rdz)
      else $error("read data outside access cycle");
   property p_mis; psel && penable && paddr[1:0] != 2'h0
      |-> pslverr && prdata == 32'h0; endproperty
   a_mis: assert property (p_mis)
      else $error("misaligned access not refused");
   property p_keep; !load_busy && !$past(psel && penable && pwrite)
      |-> $stable(cfg_regs); endproperty
   a_keep: assert property (p_keep)
      else $error("control registers changed while idle");
   property p_r10; load_busy |-> $stable(cfg_regs[0]); endproperty
   a_r10: assert property (p_r10)
      else $error("register 10h written by load");
   property p_len; $rose(load_busy) |-> ##[30:36] !load_busy; endproperty
   a_len: assert property (p_len)
      else $error("load length wrong");
   property p_fell; $fell(load_busy) |-> $past(load_busy, 30) && load_done;
   endproperty
   a_fell: assert property (p_fell)
      else $error("load ended early or without done");
endmodule
bind epl_preload epl_chk u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cfg_regs(cfg_regs), .load_busy(load_busy), .load_done(load_done));

// ==== tb/epl_host.sv ====
// apb host model driving the preload block
`timescale 1ns/100ps
module epl_host
   import epl_pkg::*;
(
   // clock
   input  wire logic        pclk,
   // apb request
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   // apb answer
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // released lines show the inverse so stale values are never trusted
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask
   task automatic load(input logic [15:0] src);
      logic [31:0] rd;
      logic        er;
      xfer(1'b1, ADDR_SRC_LO, {24'h0, src[7:0]}, rd, er);
      xfer(1'b1, ADDR_SRC_HI, {24'h0, src[15:8]}, rd, er);
      xfer(1'b1, ADDR_CMD, 32'h1, rd, er);
   endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the register preload block
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
   import epl_pkg::*;
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic             load_busy, load_done, er;
   logic [11:0]      paddr;
   logic [31:0]      pwdata, prdata, rd;
   logic [31:0][7:0] cfg_regs;
   int               errors, checks_done, cyc;
   localparam logic [7:0] VIC [32] = '{8'h00, 8'h58, 8'h3F, 8'h05, 8'h2C,
      8'h3F, 8'h3F, 8'h00, 8'h00, 8'h8B, 8'h00, 8'h54, 8'h68, 8'h00, 8'h41,
      8'h00, 8'h00, 8'h08, 8'h0C, 8'hFE, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h3E, 8'h0B, 8'h02, 8'h00, 8'h02, 8'h00, 8'h00};
   epl_preload DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cfg_regs(cfg_regs), .load_busy(load_busy), .load_done(load_done));
   epl_host host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task conclude;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      while (load_busy !== 1'b0 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      `CHK("load_busy", 1'b0, load_busy)
   endtask
   task automatic start(input logic [15:0] src, input logic busy);
      host.load(src);
      host.xfer(1'b0, ADDR_STATUS, 32'h0, rd, er);
      `CHK("busy", busy, rd[ST_BUSY_BIT])
   endtask
   task automatic t_powerup;
      wait_idle();
      `CHK("reg10", 8'h00, cfg_regs[0])
      `CHK("coder", 8'h19, cfg_regs[4])
      for (int k = 1; k < 32; k++) `CHK("prox", SET_PROX[k], cfg_regs[k])
      `CHK("done", 1'b1, load_done)
      $display("test powerup done");
   endtask
   task automatic t_vicin;
      start(16'h0030, 1'b1);
      wait_idle();
      for (int k = 1; k < 32; k++) `CHK("vicin", VIC[k], cfg_regs[k])
      `CHK("crc", 16'hFFFE, {cfg_regs[20], cfg_regs[19]})
      `CHK("water", 8'h3E, cfg_regs[25])
      `CHK("timer", 16'h0B02, {cfg_regs[26], cfg_regs[27]})
      `CHK("txctl", 8'h58, cfg_regs[1])
      $display("test vicinity done");
   endtask
   task automatic t_user;
      for (int k = 0; k < 32; k++)
         host.xfer(1'b1, 12'(12'h380 + 4 * k), {24'h0, 8'hA0 ^ 8'(k)}, rd, er);
      host.xfer(1'b0, 12'h3FC, 32'h0, rd, er);
      `CHK("mem7f", 32'h000000BF, rd)
      host.xfer(1'b1, 12'h040, 32'h5A, rd, er);
      start(16'h0060, 1'b1);
      host.xfer(1'b1, 12'h044, 32'h77, rd, er);
      `CHK("busy write", 1'b1, er)
      wait_idle();
      `CHK("reg10", 8'h5A, cfg_regs[0])
      host.xfer(1'b0, 12'h040, 32'h0, rd, er);
      `CHK("rd reg10", 32'h0000005A, rd)
      host.xfer(1'b0, 12'h0BC, 32'h0, rd, er);
      `CHK("rd reg2f", 32'h000000BF, rd)
      for (int k = 1; k < 32; k++)
         `CHK("user", 8'hA0 ^ 8'(k), cfg_regs[k])
      $display("test user set done");
   endtask
   task automatic t_bad;
      start(16'h0061, 1'b0);
      `CHK("err", 1'b1, rd[ST_ERR_BIT])
      `CHK("kept", 8'hA1, cfg_regs[1])
      host.xfer(1'b0, 12'h0C0, 32'h0, rd, er);
      `CHK("unmapped", 1'b1, er)
      host.xfer(1'b0, 12'h201, 32'h0, rd, er);
      `CHK("misaligned", 1'b1, er)
      $display("test refusal done");
   endtask
   initial begin
      cyc = 0;
      forever begin
         @(posedge pclk);
         cyc++;
         if (cyc == 5000) begin
            errors++;
            conclude();
         end
      end
   end
   initial begin
      presetn = 1'b0;
      errors = 0;
      checks_done = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_powerup();
      t_vicin();
      t_user();
      t_bad();
      conclude();
   end
endmodule
